// [core/bmtw_regs.svh]
`ifndef BMTW_REGS_SVH
`define BMTW_REGS_SVH

// Register byte offsets on the APB side.
`define BMTW_OFS_CTRL    8'h00
`define BMTW_OFS_ADDR    8'h04
`define BMTW_OFS_WDATA   8'h08
`define BMTW_OFS_RDATA   8'h0c
`define BMTW_OFS_STATUS  8'h10

// CTRL fields.
`define BMTW_CTRL_GO     0
`define BMTW_CTRL_RD     1
`define BMTW_CTRL_CRC    2
`define BMTW_CTRL_FAST   3
`define BMTW_CTRL_NORS   4
`define BMTW_CTRL_CNT_LO 8
`define BMTW_CTRL_CNT_HI 9

// STATUS fields.
`define BMTW_ST_BUSY     0
`define BMTW_ST_DONE     1
`define BMTW_ST_NACK     2
`define BMTW_ST_CRCERR   3
`define BMTW_ST_TMO      4

// Reset values.
`define BMTW_RST_DEV     8'h10
`define BMTW_RST_FAST    1'b1

// Address byte read flag and check polynomial x^8 + x^2 + x + 1.
`define BMTW_RD_FLAG     8'h01
`define BMTW_CRC_POLY    8'h07

// Timing: clock period, quarter bit times and limits.
`define BMTW_CLK_NS      20
`define BMTW_Q100_NS     2500
`define BMTW_Q400_NS     625
`define BMTW_Q100_CYC    ((`BMTW_Q100_NS + `BMTW_CLK_NS - 1) / `BMTW_CLK_NS)
`define BMTW_Q400_CYC    ((`BMTW_Q400_NS + `BMTW_CLK_NS - 1) / `BMTW_CLK_NS)
`define BMTW_STRETCH_MS  25
`define BMTW_EXT_MS      10
`define BMTW_STRETCH_CYC (`BMTW_STRETCH_MS * 1000000 / `BMTW_CLK_NS)
`define BMTW_EXT_CYC     (`BMTW_EXT_MS * 1000000 / `BMTW_CLK_NS)

`endif

// [core/bmtw_pkg.sv]
package bmtw_pkg;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_start = 2'b01,
      st_byte  = 2'b11,
      st_stop  = 2'b10
   } bmtw_st_t;

   typedef enum logic [2:0] {
      it_aw = 3'h0,
      it_ra = 3'h1,
      it_wd = 3'h2,
      it_wc = 3'h3,
      it_ar = 3'h4,
      it_rd = 3'h5,
      it_rc = 3'h6
   } bmtw_item_t;

   typedef struct packed {
      logic        scl_s1;
      logic        scl_s2;
      logic        sda_s1;
      logic        sda_s2;
      bmtw_st_t    st;
      logic [1:0]  ph;
      logic [7:0]  tmr;
      logic [3:0]  bit_i;
      bmtw_item_t  item;
      logic [7:0]  shreg;
      logic [1:0]  byte_i;
      logic        ack_rx;
      logic        restart;
      logic        scl_oe;
      logic        sda_oe;
      logic        rd;
      logic        crc_en;
      logic        fast;
      logic        no_rs;
      logic [1:0]  cnt;
      logic [7:0]  dev;
      logic [7:0]  reg_a;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        done;
      logic        nack;
      logic        crc_err;
      logic        tmo;
      logic [20:0] wait_cnt;
      logic [20:0] low_cnt;
   } bmtw_state_t;

   typedef struct packed {
      logic [7:0] crc;
   } bmtw_crc_state_t;

endpackage : bmtw_pkg

// [core/bmtw_crc_if.sv]
`timescale 1ns/1ps
interface bmtw_crc_if;
   logic       clr;
   logic       en;
   logic       din;
   logic [7:0] crc;
   modport host (output clr, output en, output din, input crc);
   modport eng  (input clr, input en, input din, output crc);
endinterface : bmtw_crc_if

// [core/bmtw_crc8.sv]
`timescale 1ns/1ps
`include "bmtw_regs.svh"
module bmtw_crc8 (
   input wire logic pclk,    // System clock.
   input wire logic presetn, // Asynchronous reset, active low.
   bmtw_crc_if.eng  cif      // Bit-serial check engine.
);
   import bmtw_pkg::*;

   bmtw_crc_state_t s_ff;
   bmtw_crc_state_t nxt_s;
   logic            fb;

   always_comb begin
      nxt_s = s_ff;
      fb    = s_ff.crc[7] ^ cif.din;
      if (cif.clr) begin
         nxt_s.crc = 8'h00;
      end else if (cif.en) begin
         nxt_s.crc = {s_ff.crc[6:0], 1'b0} ^ (fb ? `BMTW_CRC_POLY : 8'h00);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign cif.crc = s_ff.crc;

   a_crc_init_zero: assert property (@(posedge pclk) disable iff (!presetn)
      cif.clr |=> s_ff.crc == 8'h00)
      else $error("check value not zero after clear");

   a_crc_poly_step: assert property (@(posedge pclk) disable iff (!presetn)
      (cif.en && !cif.clr && cif.din && s_ff.crc == 8'h00)
      |=> s_ff.crc == 8'h07)
      else $error("check step does not follow the polynomial");

endmodule : bmtw_crc8

// [core/bmtw_ctrl.sv]
`timescale 1ns/1ps
`include "bmtw_regs.svh"
// Function
// - keep our clock-low extension under 10 ms
// - enable device timeouts only at these rates
// - several data bytes per write, pointer advances
// - single write check covers address, register, data
// - later write bytes checked over data only
// - polynomial x^8+x^2+x+1, initial zero
// - read by repeated start or stop-start
// - ACK every read byte except last
// - first read check covers all bytes since start
// - check restarts after each check byte, stop
// - NACK a wrong read check, then idle
module bmtw_ctrl #(
   parameter int STRETCH_LIMIT = `BMTW_STRETCH_CYC, // Device stretch abort.
   parameter int EXT_LIMIT     = `BMTW_EXT_CYC      // Own low extension cap.
) (
   input  wire logic        pclk,    // System clock, 50 MHz.
   input  wire logic        presetn, // Asynchronous reset, active low.
   input  wire logic        psel,    // APB select.
   input  wire logic        penable, // APB enable.
   input  wire logic        pwrite,  // APB write.
   input  wire logic [7:0]  paddr,   // APB byte address.
   input  wire logic [31:0] pwdata,  // APB write data.
   output logic      [31:0] prdata,  // APB read data.
   output logic             pready,  // APB ready.
   output logic             pslverr, // APB error on unmapped address.
   input  wire logic        scl_i,   // Clock line level.
   output logic             scl_o,   // Clock line drive value.
   output logic             scl_oe,  // Clock line pulled low when high.
   input  wire logic        sda_i,   // Data line level.
   output logic             sda_o,   // Data line drive value.
   output logic             sda_oe   // Data line pulled low when high.
);
   import bmtw_pkg::*;

   localparam logic [7:0] Q100 = 8'(`BMTW_Q100_CYC);
   localparam logic [7:0] Q400 = 8'(`BMTW_Q400_CYC);

   bmtw_state_t s_ff;
   bmtw_state_t nxt_s;
   bmtw_crc_if  cif ();

   logic       acc;
   logic       wr_acc;
   logic       busy;
   logic       tick;
   logic       last;
   logic       rx_item;
   logic       to_byte;
   logic [7:0] q;
   logic [7:0] nb;
   bmtw_item_t nitem;
   logic [1:0] nbi;

   bmtw_crc8 u_crc (
      .pclk    (pclk),
      .presetn (presetn),
      .cif     (cif)
   );

   function automatic logic [7:0] fn_byte(bmtw_item_t it, logic [1:0] bi);
      case (it)
         it_aw:   fn_byte = s_ff.dev & ~`BMTW_RD_FLAG;
         it_ra:   fn_byte = s_ff.reg_a;
         it_wd:   fn_byte = s_ff.wdata[{bi, 3'b000} +: 8];
         it_wc:   fn_byte = cif.crc;
         it_ar:   fn_byte = s_ff.dev | `BMTW_RD_FLAG;
         default: fn_byte = 8'h00;
      endcase
   endfunction : fn_byte

   assign acc     = psel & penable;
   assign wr_acc  = acc & pwrite;
   assign busy    = s_ff.st != st_idle;
   assign tick    = s_ff.tmr == 8'h00;
   assign last    = s_ff.byte_i == s_ff.cnt;
   assign rx_item = (s_ff.item == it_rd) || (s_ff.item == it_rc);
   assign q       = s_ff.fast ? Q400 : Q100;
   assign pready  = 1'b1;
   assign scl_o   = 1'b0;
   assign sda_o   = 1'b0;
   assign scl_oe  = s_ff.scl_oe;
   assign sda_oe  = s_ff.sda_oe;

   always_comb begin
      prdata  = 32'h0;
      pslverr = 1'b0;
      case (paddr)
         `BMTW_OFS_CTRL:   prdata = {22'h0, s_ff.cnt, 3'h0, s_ff.no_rs,
                                     s_ff.fast, s_ff.crc_en, s_ff.rd, 1'b0};
         `BMTW_OFS_ADDR:   prdata = {16'h0, s_ff.reg_a, s_ff.dev};
         `BMTW_OFS_WDATA:  prdata = s_ff.wdata;
         `BMTW_OFS_RDATA:  prdata = s_ff.rdata;
         `BMTW_OFS_STATUS: prdata = {27'h0, s_ff.tmo, s_ff.crc_err,
                                     s_ff.nack, s_ff.done, busy};
         default:          pslverr = acc;
      endcase
   end

   // Clears from software come first so that a hardware set in the same
   // cycle wins.
   always_comb begin
      nxt_s        = s_ff;
      nitem        = s_ff.item;
      nbi          = s_ff.byte_i;
      to_byte      = 1'b0;
      nb           = 8'h00;
      cif.clr      = 1'b0;
      cif.en       = 1'b0;
      cif.din      = s_ff.sda_s2;
      nxt_s.scl_s1 = scl_i;
      nxt_s.scl_s2 = s_ff.scl_s1;
      nxt_s.sda_s1 = sda_i;
      nxt_s.sda_s2 = s_ff.sda_s1;
      nxt_s.low_cnt = s_ff.scl_oe ? s_ff.low_cnt + 21'd1 : 21'd0;
      if (wr_acc && paddr == `BMTW_OFS_STATUS) begin
         nxt_s.done    = s_ff.done & ~pwdata[`BMTW_ST_DONE];
         nxt_s.nack    = s_ff.nack & ~pwdata[`BMTW_ST_NACK];
         nxt_s.crc_err = s_ff.crc_err & ~pwdata[`BMTW_ST_CRCERR];
         nxt_s.tmo     = s_ff.tmo & ~pwdata[`BMTW_ST_TMO];
      end
      if (!tick && !(s_ff.ph == 2'd1 && !s_ff.scl_s2)) begin
         nxt_s.tmr = s_ff.tmr - 8'd1;
      end
      if (busy && s_ff.ph == 2'd1 && !s_ff.scl_s2) begin
         nxt_s.wait_cnt = s_ff.wait_cnt + 21'd1;
      end else begin
         nxt_s.wait_cnt = 21'd0;
      end
      case (s_ff.st)
         st_idle: begin
            nxt_s.scl_oe = 1'b0;
            nxt_s.sda_oe = 1'b0;
            if (wr_acc && paddr == `BMTW_OFS_CTRL) begin
               nxt_s.rd     = pwdata[`BMTW_CTRL_RD];
               nxt_s.crc_en = pwdata[`BMTW_CTRL_CRC];
               nxt_s.fast   = pwdata[`BMTW_CTRL_FAST];
               nxt_s.no_rs  = pwdata[`BMTW_CTRL_NORS];
               nxt_s.cnt    = pwdata[`BMTW_CTRL_CNT_HI:`BMTW_CTRL_CNT_LO];
               if (pwdata[`BMTW_CTRL_GO]) begin
                  nxt_s.st      = st_start;
                  nxt_s.ph      = 2'd0;
                  nxt_s.tmr     = q;
                  nxt_s.item    = it_aw;
                  nxt_s.byte_i  = 2'd0;
                  nxt_s.restart = 1'b0;
                  nxt_s.done    = 1'b0;
                  nxt_s.nack    = 1'b0;
                  nxt_s.crc_err = 1'b0;
                  nxt_s.tmo     = 1'b0;
                  cif.clr       = 1'b1;
               end
            end
            if (wr_acc && paddr == `BMTW_OFS_ADDR) begin
               nxt_s.dev   = pwdata[7:0];
               nxt_s.reg_a = pwdata[15:8];
            end
            if (wr_acc && paddr == `BMTW_OFS_WDATA) begin
               nxt_s.wdata = pwdata;
            end
         end
         st_start: begin
            // Works from an idle bus and as a repeated start after SCL low.
            if (tick) begin
               case (s_ff.ph)
                  2'd0: begin
                     nxt_s.scl_oe = 1'b0;
                     nxt_s.ph     = 2'd1;
                     nxt_s.tmr    = q;
                  end
                  2'd1: begin
                     nxt_s.sda_oe = 1'b1;
                     nxt_s.ph     = 2'd2;
                     nxt_s.tmr    = q;
                  end
                  default: begin
                     nxt_s.scl_oe = 1'b1;
                     to_byte      = 1'b1;
                  end
               endcase
            end
         end
         st_byte: begin
            if (tick) begin
               case (s_ff.ph)
                  2'd0: begin
                     nxt_s.scl_oe = 1'b0;
                     nxt_s.ph     = 2'd1;
                     nxt_s.tmr    = q;
                  end
                  2'd1: begin
                     if (s_ff.bit_i < 4'd8) begin
                        nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sda_s2};
                        cif.en = (s_ff.item != it_wc) && (s_ff.item != it_rc);
                     end else begin
                        nxt_s.ack_rx = s_ff.sda_s2;
                     end
                     nxt_s.ph  = 2'd2;
                     nxt_s.tmr = q;
                  end
                  default: begin
                     nxt_s.scl_oe = 1'b1;
                     nxt_s.ph     = 2'd0;
                     nxt_s.tmr    = {q[6:0], 1'b0};
                     if (s_ff.bit_i < 4'd8) begin
                        nxt_s.bit_i = s_ff.bit_i + 4'd1;
                        if (s_ff.bit_i != 4'd7) begin
                           nxt_s.sda_oe = !rx_item && !s_ff.shreg[7];
                        end else if (s_ff.item == it_rd) begin
                           nxt_s.sda_oe = s_ff.crc_en || !last;
                        end else if (s_ff.item == it_rc) begin
                           nxt_s.sda_oe = (s_ff.shreg == cif.crc) && !last;
                        end else begin
                           nxt_s.sda_oe = 1'b0;
                        end
                     end else if (!rx_item && s_ff.ack_rx) begin
                        nxt_s.nack = 1'b1;
                        nxt_s.st   = st_stop;
                     end else begin
                        case (s_ff.item)
                           it_aw: begin
                              nitem   = it_ra;
                              to_byte = 1'b1;
                           end
                           it_ra: begin
                              if (!s_ff.rd) begin
                                 nitem   = it_wd;
                                 to_byte = 1'b1;
                              end else if (s_ff.no_rs) begin
                                 nxt_s.restart = 1'b1;
                                 nxt_s.st      = st_stop;
                              end else begin
                                 nxt_s.item   = it_ar;
                                 nxt_s.st     = st_start;
                                 nxt_s.sda_oe = 1'b0;
                                 nxt_s.tmr    = q;
                              end
                           end
                           it_wd, it_wc: begin
                              if (s_ff.item == it_wd && s_ff.crc_en) begin
                                 nitem   = it_wc;
                                 to_byte = 1'b1;
                              end else if (last) begin
                                 nxt_s.st = st_stop;
                              end else begin
                                 nitem   = it_wd;
                                 nbi     = s_ff.byte_i + 2'd1;
                                 to_byte = 1'b1;
                              end
                              cif.clr = s_ff.item == it_wc;
                           end
                           it_ar: begin
                              nitem   = it_rd;
                              to_byte = 1'b1;
                           end
                           default: begin
                              if (s_ff.item == it_rd) begin
                                 nxt_s.rdata[{s_ff.byte_i, 3'b000} +: 8] =
                                    s_ff.shreg;
                              end
                              cif.clr = s_ff.item == it_rc;
                              if (s_ff.item == it_rd && s_ff.crc_en) begin
                                 nitem   = it_rc;
                                 to_byte = 1'b1;
                              end else if (s_ff.item == it_rc &&
                                           s_ff.shreg != cif.crc) begin
                                 nxt_s.crc_err = 1'b1;
                                 nxt_s.st      = st_stop;
                              end else if (last) begin
                                 nxt_s.st = st_stop;
                              end else begin
                                 nitem   = it_rd;
                                 nbi     = s_ff.byte_i + 2'd1;
                                 to_byte = 1'b1;
                              end
                           end
                        endcase
                        if (nxt_s.st == st_stop) begin
                           nxt_s.sda_oe = 1'b1;
                           nxt_s.tmr    = q;
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            if (tick) begin
               case (s_ff.ph)
                  2'd0: begin
                     nxt_s.scl_oe = 1'b0;
                     nxt_s.ph     = 2'd1;
                     nxt_s.tmr    = q;
                  end
                  2'd1: begin
                     nxt_s.sda_oe = 1'b0;
                     nxt_s.ph     = 2'd2;
                     nxt_s.tmr    = q;
                  end
                  default: begin
                     cif.clr  = 1'b1;
                     nxt_s.ph = 2'd0;
                     nxt_s.tmr = q;
                     if (s_ff.restart) begin
                        nxt_s.restart = 1'b0;
                        nxt_s.item    = it_ar;
                        nxt_s.st      = st_start;
                     end else begin
                        nxt_s.st   = st_idle;
                        nxt_s.done = 1'b1;
                     end
                  end
               endcase
            end
         end
      endcase
      if (to_byte) begin
         nb           = fn_byte(nitem, nbi);
         nxt_s.st     = st_byte;
         nxt_s.item   = nitem;
         nxt_s.byte_i = nbi;
         nxt_s.shreg  = nb;
         nxt_s.bit_i  = 4'd0;
         nxt_s.ph     = 2'd0;
         nxt_s.tmr    = {q[6:0], 1'b0};
         nxt_s.sda_oe = (nitem != it_rd) && (nitem != it_rc) && !nb[7];
      end
      // A device that holds SCL too long ends the transfer; both lines
      // are released so that its own timeout can recover the bus.
      if (s_ff.wait_cnt >= 21'(STRETCH_LIMIT)) begin
         nxt_s.st      = st_idle;
         nxt_s.scl_oe  = 1'b0;
         nxt_s.sda_oe  = 1'b0;
         nxt_s.restart = 1'b0;
         nxt_s.tmo     = 1'b1;
         nxt_s.done    = 1'b1;
         cif.clr       = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff       <= '0;
         s_ff.st    <= st_idle;
         s_ff.item  <= it_aw;
         s_ff.fast  <= `BMTW_RST_FAST;
         s_ff.dev   <= `BMTW_RST_DEV;
         s_ff.scl_s1 <= 1'b1;
         s_ff.scl_s2 <= 1'b1;
         s_ff.sda_s1 <= 1'b1;
         s_ff.sda_s2 <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   a_ext_low_limit: assert property (@(posedge pclk) disable iff (!presetn)
      s_ff.low_cnt < 21'(EXT_LIMIT))
      else $error("own clock-low extension too long");

   a_rd_ack_last: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.st == st_byte && s_ff.item == it_rd && s_ff.bit_i == 4'd8)
      |-> s_ff.sda_oe == (s_ff.crc_en || !last))
      else $error("wrong acknowledge on read data byte");

   a_rd_crc_nack: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.st == st_byte && s_ff.item == it_rc && s_ff.bit_i == 4'd8
       && s_ff.shreg != cif.crc) |-> !s_ff.sda_oe)
      else $error("bad read check byte not refused");

   a_wr_crc_load: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_ff.st == st_byte && s_ff.item == it_wc)
      |-> s_ff.shreg == cif.crc && s_ff.sda_oe == !cif.crc[7])
      else $error("write check byte not loaded from engine");

   a_byte_step: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.st == st_byte && $changed(s_ff.byte_i))
      |-> s_ff.byte_i == 2'($past(s_ff.byte_i) + 2'd1))
      else $error("byte index did not advance by one");

   a_rs_path: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.st == st_byte && s_ff.item == it_ra && s_ff.rd && !s_ff.no_rs
       && s_ff.bit_i == 4'd8 && s_ff.ph == 2'd2 && tick && !s_ff.ack_rx)
      |=> s_ff.st == st_start && s_ff.item == it_ar && !s_ff.sda_oe)
      else $error("repeated start not issued");

   a_stop_crc_clr: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(s_ff.st == st_stop) |-> cif.crc == 8'h00)
      else $error("check value kept across stop");

   a_rs_crc_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.st == st_start && s_ff.item == it_ar) |=> $stable(cif.crc))
      else $error("check value changed during repeated start");

endmodule : bmtw_ctrl

// [tb/bmtw_dev.sv]
`timescale 1ns/1ps
module bmtw_dev (
   input  wire logic        scl,        // Clock line level.
   input  wire logic        sda,        // Data line level.
   input  wire logic        crc_on,     // Check bytes in use.
   input  wire logic        bad_crc,    // Corrupt read check bytes.
   input  wire logic [15:0] stretch_ns, // Clock hold after each ack.
   output logic             scl_pull,   // High pulls clock low.
   output logic             sda_pull    // High pulls data low.
);
   parameter logic [7:0] DEV = 8'h10;
   logic [7:0] mem [256];
   logic [7:0] ptr, c, b, d;
   logic       a, rs;

   function automatic logic [7:0] cs(logic [7:0] x, logic [7:0] v);
      x = x ^ v;
      repeat (8) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction : cs

   task automatic get(output logic [7:0] v);
      repeat (8) begin
         @(posedge scl);
         v = {v[6:0], sda};
      end
   endtask : get

   // Holding the clock after an ack lets slow answers be tried; data is
   // set while the clock is held so that no false start or stop appears.
   task automatic ack(input logic k, input logic nb);
      @(negedge scl);
      #100 sda_pull = k;
      @(negedge scl);
      scl_pull = 1;
      #100 sda_pull = nb;
      #(stretch_ns);
      scl_pull = 0;
   endtask : ack

   // The host moves SDA in the cycle in which it pulls SCL low, so an SDA
   // edge counts as a condition only if SCL is still high just after it.
   task automatic cond(input logic up);
      forever begin
         if (up) @(posedge sda);
         else @(negedge sda);
         #1;
         if (scl) break;
      end
   endtask : cond

   task automatic put(input logic [7:0] v, output logic k);
      for (int i = 7; i >= 0; i--) begin
         sda_pull = !v[i];
         @(negedge scl);
         #100;
      end
      sda_pull = 0;
      @(posedge scl);
      k = !sda;
      @(negedge scl);
      #100;
   endtask : put

   task automatic xfer();
      get(b);
      c = cs(c, b);
      if (b[7:1] !== DEV[7:1]) wait (0);
      if (b[0]) begin
         d = mem[ptr];
         ack(1, !d[7]);
         forever begin
            d = mem[ptr];
            ptr++;
            c = cs(c, d);
            put(d, a);
            if (crc_on) put(c ^ {8{bad_crc}}, a);
            c = 0;
            if (!a) wait (0);
         end
      end
      ack(1, 0);
      get(ptr);
      c = cs(c, ptr);
      ack(1, 0);
      forever begin
         get(d);
         c = cs(c, d);
         ack(1, 0);
         if (crc_on) begin
            get(b);
            if (b !== c) begin
               ack(0, 0);
               wait (0);
            end
            ack(1, 0);
         end
         mem[ptr] = d;
         ptr++;
         c = 0;
      end
   endtask : xfer

   initial begin
      sda_pull = 0;
      scl_pull = 0;
      c = 0;
      rs = 0;
      forever begin
         if (!rs) cond(0);
         rs = 0;
         fork : f_x
            begin cond(1); c = 0; end
            begin cond(0); rs = 1; end
            xfer();
         join_any
         disable f_x;
         sda_pull = 0;
         scl_pull = 0;
      end
   end
endmodule : bmtw_dev

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, scl_oe, sda_oe;
   logic        scl_pull, sda_pull, crc_on, bad_crc;
   logic [15:0] stretch_ns;
   int          n_fail = 0;
   int          checks_done = 0;
   wire         scl = !(scl_oe | scl_pull);
   wire         sda = !(sda_oe | sda_pull);

   bmtw_ctrl #(.STRETCH_LIMIT(2000), .EXT_LIMIT(600)) u_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda),
      .sda_o(), .sda_oe);
   bmtw_dev u_dev (.scl, .sda, .crc_on, .bad_crc, .stretch_ns, .scl_pull,
      .sda_pull);

   initial begin
      pclk = 0;
      forever #10 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb

   function automatic logic [31:0] cw(logic rd, logic crc, logic fast,
                                      logic nors, logic [1:0] n);
      return {22'h0, n, 3'h0, nors, fast, crc, rd, 1'b1};
   endfunction : cw

   // Starts a transfer and waits for busy to drop.
   task automatic run(input logic [31:0] ctl, input logic [31:0] st);
      logic [31:0] q;
      logic        e;
      apb(1, 8'h00, ctl, q, e);
      do apb(0, 8'h10, 0, q, e);
      while (q[0] !== 1'b0);
      chk("status", st, q);
   endtask : run

   initial begin
      #3000000;
      n_fail++;
      end_sim();
   end

   initial begin
      logic [31:0] q, d;
      logic [7:0]  r;
      logic        e;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {crc_on, bad_crc, stretch_ns} = '0;
      q = $urandom(68);
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 8'h00, 0, q, e);
      chk("ctrl", 32'h8, q);
      apb(0, 8'h04, 0, q, e);
      chk("addr", 32'h10, q);
      apb(0, 8'h14, 0, q, e);
      chk("slverr", 32'h1, {31'h0, e});
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom);
         d = $urandom;
         crc_on <= i[0];
         stretch_ns <= 16'($urandom_range(0, 1000));
         apb(1, 8'h04, {16'h0, r, 8'h10}, q, e);
         apb(1, 8'h08, d, q, e);
         run(cw(0, i[0], i != 0, i[1], 2'(i)), 32'h2);
         run(cw(1, i[0], i != 0, i[1], 2'(i)), 32'h2);
         apb(0, 8'h0c, 0, q, e);
         d = d & (32'hffffffff >> (8 * (3 - i)));
         chk("rdata", d, q & (32'hffffffff >> (8 * (3 - i))));
      end
      crc_on <= 1;
      bad_crc <= 1;
      run(cw(1, 1, 1, 0, 0), 32'ha);
      bad_crc <= 0;
      apb(1, 8'h04, 32'h20, q, e);
      run(cw(0, 0, 1, 0, 0), 32'h6);
      apb(1, 8'h04, 32'h10, q, e);
      stretch_ns <= 16'd60000;
      run(cw(0, 0, 1, 0, 0), 32'h12);
      end_sim();
   end
endmodule : tb
